//--- design/fdf_defs.svh
/*
 Constants of the fault detection and filter block: register offsets,
 field positions, reset values and timing figures.
 Assumes a 32-bit APB register bus and a 250 MHz system clock.
*/
`ifndef FDF_DEFS_SVH
`define FDF_DEFS_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define FDF_AW 12
`define FDF_A_SETUP 12'h000
`define FDF_A_STATUS 12'h004
`define FDF_A_MASK 12'h008
`define FDF_A_CTRL 12'h00c
`define FDF_A_OV 12'h010
`define FDF_A_UV 12'h014
`define FDF_A_OW 12'h018
`define FDF_A_OT 12'h01c
// ****************************************
// Field positions and reset values
// ****************************************
`define FDF_SETUP_W 13
`define FDF_SETUP_RST 13'h0000
`define FDF_SCN_LSB 0
`define FDF_SCN_MSB 3
`define FDF_TOT_LSB 5
`define FDF_TOT_MSB 7
`define FDF_SCN_MAX 4'hc
`define FDF_STAT_W 8
`define FDF_STAT_OV 0
`define FDF_STAT_UV 1
`define FDF_STAT_OW 2
`define FDF_STAT_OT 3
`define FDF_STAT_BAT 4
`define FDF_STAT_GND 5
`define FDF_STAT_REG 6
`define FDF_STAT_OSC 7
`define FDF_MASK_RST 8'hff
`define FDF_CTRL_CONT 0
// ****************************************
// Timing
// ****************************************
`define FDF_CLK_PERIOD_NS 4
`define FDF_MS_NS 1000000
`define FDF_MS_CYCLES (`FDF_MS_NS / `FDF_CLK_PERIOD_NS)
`define FDF_BASE_INTERVAL_MS 17'h00010
`define FDF_CNT_W 8
`endif

//--- design/fdf_pkg.sv
/*
 Types shared by the fault detection and filter block.
 Assumes fdf_defs.svh for numeric constants.
*/
package fdf_pkg;
  // Synchronised monitor pins
  typedef struct packed {
    logic osc;
    logic rail_ref;
    logic internal_rail_mid;
    logic internal_rail_high;
  } fdf_mon_t;
  // APB request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fdf_apb_req_t;
endpackage : fdf_pkg

//--- design/fdf_top.sv
/*
 Fault detection and filtering: supply and oscillator alarms, scan-sampled
 cell and connection faults with totalizing filters, APB registers, irq.
 Assumes scan results arrive as same-clock pulses; monitor pins are async.
*/
// What this block does
// RULE_01: A rail leaving its window sets the regulator fault and the alarm at once.
// RULE_02: An oscillator deviation sets the oscillator fault and the alarm at once.
// RULE_03: Each cell has its own OV, UV, temperature and wire bit, ORed into one status bit each.
// RULE_04: Open pack supply and open ground each own one status bit.
// RULE_05: OV, UV, open supply and open ground are sampled together when a voltage scan ends.
// RULE_06: OV and UV are also sampled when a single cell measurement ends.
// RULE_07: In continuous mode the block requests every scan itself.
// RULE_08: Outside continuous mode the host reissues scans to keep rechecking.
// RULE_09: A fault needs an unbroken run of 1 to 128 positives chosen by a 3-bit code.
// RULE_10: Every cell input, the supply test and the ground test filter independently; wire and temperature results set their bits unfiltered.
// RULE_11: A negative sample clears that filter's run.
// RULE_12: A host write that clears any set status bit clears all filters.
// RULE_13: The host rewrites the status bits to clear a fault and restart filtering.
// RULE_14: Every validated fault raises the alarm.
// RULE_15: A 4-bit code sets the scan interval, 16 ms doubling up to 65536 ms.
// RULE_16: Detection time in continuous mode is interval times sample count.
// RULE_17: A validated fault bit stays set until the host rewrites status.
`timescale 1ns/1ps
`include "fdf_defs.svh"
module fdf_top #(
  parameter int N_CELLS = 12,
  parameter int MS_CYCLES = `FDF_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // APB slave
  input wire fdf_pkg::fdf_apb_req_t apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Asynchronous monitor pins
  input wire fdf_pkg::fdf_mon_t mon_in,
  // Scan results
  input wire logic volt_done_in,
  input wire logic meas_done_in,
  input wire logic [N_CELLS-1:0] ov_res_in,
  input wire logic [N_CELLS-1:0] uv_res_in,
  input wire logic open_bat_res_in,
  input wire logic open_gnd_res_in,
  input wire logic wire_done_in,
  input wire logic [N_CELLS-1:0] wire_res_in,
  input wire logic temp_done_in,
  input wire logic [N_CELLS-1:0] temp_res_in,
  // Scan request and fault outputs
  output logic scan_req_out,
  output logic alarm_out,
  output logic irq_out
);
  import fdf_pkg::*;
  localparam int NF = 2 * N_CELLS + 2;

  initial begin
    if (N_CELLS < 1 || N_CELLS > 32 || MS_CYCLES < 1 || MS_CYCLES > 262143) begin
      $error("fdf_top: unsupported parameter value");
    end
  end

  // ****************************************
  // Reset and pin synchronisers
  // ****************************************
  logic [1:0] rst_sync_ff;
  logic rst_n;
  fdf_mon_t mon_s1_ff, mon_ff;

  // Reset release through two flops
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Two-flop monitor synchroniser
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      mon_s1_ff <= '0;
      mon_ff <= '0;
    end else begin
      mon_s1_ff <= mon_in;
      mon_ff <= mon_s1_ff;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic [`FDF_SETUP_W-1:0] setup_ff;
  logic [`FDF_STAT_W-1:0] mask_ff, status;
  logic cont_ff, bat_ff, gnd_ff, reg_ff, osc_ff;
  logic [N_CELLS-1:0] ov_ff, uv_ff, ow_ff, ot_ff;
  logic acc, wr, stat_wr, clr_all;
  logic [`FDF_STAT_W-1:0] w1c;
  logic [31:0] rdata;
  logic hit;

  assign acc = apb_in.psel && apb_in.penable;
  assign wr = acc && pready_out && apb_in.pwrite;
  assign stat_wr = wr && apb_in.paddr == `FDF_A_STATUS;
  assign w1c = stat_wr ? apb_in.pwdata[`FDF_STAT_W-1:0] : '0;
  assign clr_all = |(w1c & status); // RULE_12 RULE_13
  assign status = {osc_ff, reg_ff, gnd_ff, bat_ff, |ot_ff, |ow_ff, |uv_ff, |ov_ff}; // RULE_03 RULE_04

  // Read decode
  always_comb begin
    rdata = 32'h0;
    hit = 1'b1;
    case (apb_in.paddr)
      `FDF_A_SETUP: rdata[`FDF_SETUP_W-1:0] = setup_ff;
      `FDF_A_STATUS: rdata[`FDF_STAT_W-1:0] = status;
      `FDF_A_MASK: rdata[`FDF_STAT_W-1:0] = mask_ff;
      `FDF_A_CTRL: rdata[`FDF_CTRL_CONT] = cont_ff;
      `FDF_A_OV: rdata[N_CELLS-1:0] = ov_ff;
      `FDF_A_UV: rdata[N_CELLS-1:0] = uv_ff;
      `FDF_A_OW: rdata[N_CELLS-1:0] = ow_ff;
      `FDF_A_OT: rdata[N_CELLS-1:0] = ot_ff;
      default: hit = 1'b0;
    endcase
  end

  // One wait state, then ready with registered data
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else if (acc && !pready_out) begin
      pready_out <= 1'b1;
      prdata_out <= apb_in.pwrite ? 32'h0 : rdata;
      pslverr_out <= !hit;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // Writable configuration
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      setup_ff <= `FDF_SETUP_RST;
      mask_ff <= `FDF_MASK_RST;
      cont_ff <= 1'b0;
    end else if (wr) begin
      case (apb_in.paddr)
        `FDF_A_SETUP: setup_ff <= apb_in.pwdata[`FDF_SETUP_W-1:0];
        `FDF_A_MASK: mask_ff <= apb_in.pwdata[`FDF_STAT_W-1:0];
        `FDF_A_CTRL: cont_ff <= apb_in.pwdata[`FDF_CTRL_CONT];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Continuous scan timer
  // ****************************************
  logic [3:0] scan_interval_code;
  logic [16:0] iv_cnt_ff, iv_len;
  logic [17:0] pre_ff;
  logic ms_tick;

  assign scan_interval_code = setup_ff[`FDF_SCN_MSB:`FDF_SCN_LSB] > `FDF_SCN_MAX ? `FDF_SCN_MAX :
               setup_ff[`FDF_SCN_MSB:`FDF_SCN_LSB];
  assign iv_len = `FDF_BASE_INTERVAL_MS << scan_interval_code; // RULE_15
  assign ms_tick = pre_ff == 18'(MS_CYCLES - 1);

  // Millisecond divider and interval count
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 18'h0;
      iv_cnt_ff <= 17'h0;
      scan_req_out <= 1'b0;
    end else if (!cont_ff) begin
      pre_ff <= 18'h0;
      iv_cnt_ff <= 17'h0;
      scan_req_out <= 1'b0;
    end else begin
      pre_ff <= ms_tick ? 18'h0 : pre_ff + 18'h1;
      scan_req_out <= ms_tick && iv_cnt_ff >= iv_len - 17'h1; // RULE_07 RULE_16
      if (ms_tick) begin
        iv_cnt_ff <= iv_cnt_ff >= iv_len - 17'h1 ? 17'h0 : iv_cnt_ff + 17'h1;
      end
    end
  end

  // ****************************************
  // Totalizing filters
  // ****************************************
  logic [NF-1:0] samp_en, samp_pos, valid;
  logic [`FDF_CNT_W-1:0] target;
  logic [`FDF_CNT_W-1:0] cnt_ff [NF];

  assign target = `FDF_CNT_W'(1) << setup_ff[`FDF_TOT_MSB:`FDF_TOT_LSB]; // RULE_09
  assign samp_pos = {open_gnd_res_in, open_bat_res_in, uv_res_in, ov_res_in};
  // Cells on voltage scan or measure; connections on voltage scan only
  assign samp_en = {{2{volt_done_in}}, {(2*N_CELLS){volt_done_in | meas_done_in}}}; // RULE_05 RULE_06

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_filt
      assign valid[gi] = samp_en[gi] && samp_pos[gi] && cnt_ff[gi] + `FDF_CNT_W'(1) >= target;
      // One independent run counter per test
      always_ff @(posedge clk_sys_in or negedge rst_n) begin // RULE_10
        if (!rst_n) begin
          cnt_ff[gi] <= '0;
        end else if (clr_all) begin
          cnt_ff[gi] <= '0; // RULE_12
        end else if (samp_en[gi] && !samp_pos[gi]) begin
          cnt_ff[gi] <= '0; // RULE_11
        end else if (samp_en[gi] && cnt_ff[gi] < target) begin
          cnt_ff[gi] <= cnt_ff[gi] + `FDF_CNT_W'(1); // RULE_09
        end
      end
    end
  endgenerate

  // ****************************************
  // Fault flags, set wins over clear
  // ****************************************
  logic [N_CELLS-1:0] wire_set, temp_set;
  assign wire_set = wire_done_in ? wire_res_in : '0;
  assign temp_set = temp_done_in ? temp_res_in : '0;

  // Per-cell fault bits
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ov_ff <= '0;
      uv_ff <= '0;
      ow_ff <= '0;
      ot_ff <= '0;
    end else begin
      ov_ff <= (w1c[`FDF_STAT_OV] ? '0 : ov_ff) | valid[N_CELLS-1:0]; // RULE_17
      uv_ff <= (w1c[`FDF_STAT_UV] ? '0 : uv_ff) | valid[2*N_CELLS-1:N_CELLS]; // RULE_17
      ow_ff <= (w1c[`FDF_STAT_OW] ? '0 : ow_ff) | wire_set; // RULE_03
      ot_ff <= (w1c[`FDF_STAT_OT] ? '0 : ot_ff) | temp_set; // RULE_03
    end
  end

  // Connection, rail and oscillator bits
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      bat_ff <= 1'b0;
      gnd_ff <= 1'b0;
      reg_ff <= 1'b0;
      osc_ff <= 1'b0;
    end else begin
      bat_ff <= (bat_ff && !w1c[`FDF_STAT_BAT]) || valid[2*N_CELLS]; // RULE_04
      gnd_ff <= (gnd_ff && !w1c[`FDF_STAT_GND]) || valid[2*N_CELLS+1]; // RULE_04
      reg_ff <= (reg_ff && !w1c[`FDF_STAT_REG]) || mon_ff.internal_rail_high ||
                mon_ff.internal_rail_mid || mon_ff.rail_ref; // RULE_01
      osc_ff <= (osc_ff && !w1c[`FDF_STAT_OSC]) || mon_ff.osc; // RULE_02
    end
  end

  // Alarm on any fault, interrupt on unmasked faults
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      alarm_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      alarm_out <= |status; // RULE_14
      irq_out <= |(status & mask_ff);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n);

  AST_RAIL: assert property (mon_ff.internal_rail_high || mon_ff.internal_rail_mid // RULE_01
    || mon_ff.rail_ref |=> reg_ff ##1 alarm_out)
    else $error("rail fault not flagged");
  AST_OSC: assert property (mon_ff.osc |=> osc_ff ##1 alarm_out) // RULE_02
    else $error("oscillator fault not flagged");
  AST_SUMMARY: assert property (valid[0] |=> status[`FDF_STAT_OV]) // RULE_03
    else $error("ov summary missing");
  AST_NO_SCAN: assert property (!volt_done_in && !meas_done_in |=> !$rose(ov_ff[0])) // RULE_05
    else $error("ov bit set without scan");
  AST_MEAS: assert property (meas_done_in && !volt_done_in && !w1c[`FDF_STAT_BAT] // RULE_06
    |=> $stable(bat_ff))
    else $error("supply bit moved on measure");
  AST_CONT: assert property (scan_req_out |-> $past(cont_ff) ##1 !scan_req_out) // RULE_07
    else $error("scan request outside continuous mode");
  AST_NEG: assert property (meas_done_in && !ov_res_in[0] |=> cnt_ff[0] == '0) // RULE_11
    else $error("filter not cleared on negative");
  AST_CLR: assert property (clr_all |=> cnt_ff[0] == '0 && cnt_ff[NF-1] == '0) // RULE_12
    else $error("filters not cleared on status change");
  AST_TOT: assert property ($rose(ov_ff[0]) |-> $past(cnt_ff[0]) + 8'h1 >= $past(target)) // RULE_09
    else $error("fault validated before count");
  AST_STICKY: assert property (ov_ff[0] && !w1c[`FDF_STAT_OV] |=> ov_ff[0]) // RULE_17
    else $error("fault bit dropped");
  AST_IVAL: assert property (ms_tick && cont_ff |=> iv_cnt_ff < $past(iv_len)) // RULE_15 RULE_16
    else $error("interval count overran");

  COV_VALID: cover property (valid[0]);
  COV_SCAN: cover property (scan_req_out);
  COV_CLR: cover property (clr_all);
  COV_IRQ: cover property ($rose(irq_out));
endmodule : fdf_top

//--- verification/fdf_scan_model.sv
/*
 Scan engine model on the far side of fdf_top: answers scan requests
 and host commands with done pulses and per-cell results.
 Assumes one clock shared with the design; commands are one-cycle pulses.
*/
`timescale 1ns/1ps
module fdf_scan_model #(
  parameter int N = 4,
  parameter int DELAY = 3
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Requests: cmd bit 0 volt, 1 measure, 2 wire, 3 temp
  input wire logic scan_req_in,
  input wire logic [3:0] cmd_in,
  // Fault pattern to report
  input wire logic [N-1:0] ov_set_in,
  input wire logic [N-1:0] uv_set_in,
  input wire logic [N-1:0] wire_set_in,
  input wire logic [N-1:0] temp_set_in,
  input wire logic bat_set_in,
  input wire logic gnd_set_in,
  // Results
  output logic [3:0] done_out,
  output logic [N-1:0] ov_res_out,
  output logic [N-1:0] uv_res_out,
  output logic [N-1:0] wire_res_out,
  output logic [N-1:0] temp_res_out,
  output logic bat_res_out,
  output logic gnd_res_out
);
  // ****************************************
  // Scan sequencing
  // ****************************************
  logic [3:0] kind_ff;
  logic [7:0] cnt_ff;
  logic any;
  // Continuous request runs a voltage scan without host help
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kind_ff <= 4'h0;
      cnt_ff <= 8'h00;
      done_out <= 4'h0;
    end else begin
      done_out <= 4'h0;
      if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
        if (cnt_ff == 8'h01) done_out <= kind_ff;
      end else if (cmd_in != 4'h0 || scan_req_in) begin
        kind_ff <= cmd_in | {3'h0, scan_req_in};
        cnt_ff <= 8'(DELAY);
      end
    end
  end
  // Results valid with done only; inverted otherwise
  assign any = (done_out != 4'h0);
  assign ov_res_out = any ? ov_set_in : ~ov_set_in;
  assign uv_res_out = any ? uv_set_in : ~uv_set_in;
  assign wire_res_out = any ? wire_set_in : ~wire_set_in;
  assign temp_res_out = any ? temp_set_in : ~temp_set_in;
  assign bat_res_out = any ? bat_set_in : ~bat_set_in;
  assign gnd_res_out = any ? gnd_set_in : ~gnd_set_in;
endmodule : fdf_scan_model

//--- verification/fault_detect_filter_bench.sv
/*
 Self-checking bench of fdf_top: APB tasks, scan model, register checks.
 Assumes fdf_defs.svh on the include path and short millisecond count.
*/
`timescale 1ns/1ps
`include "fdf_defs.svh"
module fault_detect_filter_bench;
  import fdf_pkg::*;
  localparam int NC = 4;
  localparam int MS = 4;
  localparam logic [3:0] PAT [8] = '{4'h3, 4'h3, 4'h3, 4'h1, 4'h3, 4'h3, 4'h3, 4'h3};
  localparam logic [3:0] EXP [8] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h3};
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  fdf_apb_req_t req = '0;
  fdf_mon_t mon = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, scan_req, alarm, irq, er;
  logic [3:0] cmd = 4'h0;
  logic [3:0] done;
  logic [NC-1:0] ov_s = '0, uv_s = '0, wr_s = '0, tp_s = '0, ov_r, uv_r, wr_r, tp_r;
  logic b_s = 1'b0, g_s = 1'b0, b_r, g_r;
  int error_cnt = 0, checks = 0, gap = 0, cnt = 0;
  // ****************************************
  // Design, scan model, clock
  // ****************************************
  fdf_top #(.N_CELLS(NC), .MS_CYCLES(MS)) dut_u (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .apb_in(req), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .mon_in(mon), .volt_done_in(done[0]), .meas_done_in(done[1]),
    .ov_res_in(ov_r), .uv_res_in(uv_r), .open_bat_res_in(b_r), .open_gnd_res_in(g_r),
    .wire_done_in(done[2]), .wire_res_in(wr_r), .temp_done_in(done[3]),
    .temp_res_in(tp_r), .scan_req_out(scan_req), .alarm_out(alarm), .irq_out(irq));
  fdf_scan_model #(.N(NC), .DELAY(3)) scan_u (.clk_in(clk_sys_in), .rst_n_in(rst_n_in),
    .scan_req_in(scan_req), .cmd_in(cmd), .ov_set_in(ov_s), .uv_set_in(uv_s),
    .wire_set_in(wr_s), .temp_set_in(tp_s), .bat_set_in(b_s), .gnd_set_in(g_s),
    .done_out(done), .ov_res_out(ov_r), .uv_res_out(uv_r), .wire_res_out(wr_r),
    .temp_res_out(tp_r), .bat_res_out(b_r), .gnd_res_out(g_r));
  initial forever #2 clk_sys_in = ~clk_sys_in;
  // Cycles between scan requests
  always @(posedge clk_sys_in) begin
    if (scan_req === 1'b1) begin
      gap <= cnt;
      cnt <= 1;
    end else cnt <= cnt + 1;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    finish_test();
  end
  // ****************************************
  // Tasks
  // ****************************************
  task finish_test();
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task idle(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask : idle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rdc
  // Host command with the pattern the scan reports
  task scan(input logic [3:0] k, input logic [NC-1:0] o, u, w, t, input logic b, g);
    ov_s <= o;
    uv_s <= u;
    wr_s <= w;
    tp_s <= t;
    b_s <= b;
    g_s <= g;
    cmd <= k;
    @(posedge clk_sys_in);
    cmd <= 4'h0;
    idle(10);
  endtask : scan
  task wait_req();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (scan_req !== 1'b1 && n < 1000);
    if (n >= 1000) error_cnt++;
  endtask : wait_req
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    idle(5);
    rst_n_in <= 1'b1;
    idle(4);
    chk("alarm_out", 32'h0, {31'h0, alarm});
    rdc(`FDF_A_SETUP, 32'h0);
    rdc(`FDF_A_MASK, 32'hff);
    rdc(`FDF_A_STATUS, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    wr(`FDF_A_SETUP, 32'hffffffff);
    rdc(`FDF_A_SETUP, 32'h1fff);
    wr(`FDF_A_SETUP, 32'h40);
    for (int i = 0; i < 8; i++) begin
      scan(4'h1, PAT[i], '0, '0, '0, 1'b0, 1'b0);
      rdc(`FDF_A_OV, {28'h0, EXP[i]});
    end
    rdc(`FDF_A_STATUS, 32'h1);
    chk("alarm_out", 32'h1, {31'h0, alarm});
    chk("irq_out", 32'h1, {31'h0, irq});
    wr(`FDF_A_STATUS, 32'h1);
    rdc(`FDF_A_OV, 32'h0);
    chk("alarm_out", 32'h0, {31'h0, alarm});
    for (int i = 0; i < 2; i++) scan(4'h1, 4'h4, '0, '0, '0, 1'b0, 1'b0);
    scan(4'h8, '0, '0, '0, 4'h1, 1'b0, 1'b0);
    rdc(`FDF_A_OT, 32'h1);
    wr(`FDF_A_STATUS, 32'h8);
    for (int i = 0; i < 2; i++) scan(4'h1, 4'h4, '0, '0, '0, 1'b0, 1'b0);
    rdc(`FDF_A_OV, 32'h0);
    for (int i = 0; i < 2; i++) scan(4'h1, 4'h4, '0, '0, '0, 1'b0, 1'b0);
    rdc(`FDF_A_OV, 32'h4);
    wr(`FDF_A_STATUS, 32'hff);
    wr(`FDF_A_SETUP, 32'h0);
    scan(4'h2, '0, 4'h4, '0, '0, 1'b1, 1'b1);
    rdc(`FDF_A_STATUS, 32'h2);
    rdc(`FDF_A_UV, 32'h4);
    scan(4'h1, 4'h8, '0, '0, '0, 1'b1, 1'b1);
    rdc(`FDF_A_STATUS, 32'h33);
    scan(4'h4, '0, '0, 4'h2, '0, 1'b0, 1'b0);
    rdc(`FDF_A_OW, 32'h2);
    wr(`FDF_A_MASK, 32'h0);
    idle(3);
    chk("irq_out", 32'h0, {31'h0, irq});
    chk("alarm_out", 32'h1, {31'h0, alarm});
    wr(`FDF_A_MASK, 32'h4);
    idle(3);
    chk("irq_out", 32'h1, {31'h0, irq});
    wr(`FDF_A_STATUS, 32'h4);
    idle(3);
    chk("irq_out", 32'h0, {31'h0, irq});
    wr(`FDF_A_STATUS, 32'hff);
    wr(`FDF_A_MASK, 32'hff);
    // Each of the three rails alone raises the regulator fault
    for (int r = 0; r < 3; r++) begin
      wr(`FDF_A_STATUS, 32'hff);
      mon <= fdf_mon_t'(4'h1 << r);
      idle(6);
      rdc(`FDF_A_STATUS, 32'h40);
      chk("alarm_out", 32'h1, {31'h0, alarm});
      mon <= '0;
      idle(4);
    end
    mon.osc <= 1'b1;
    idle(6);
    wr(`FDF_A_STATUS, 32'h40);
    rdc(`FDF_A_STATUS, 32'h80);
    mon.osc <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      wr(`FDF_A_CTRL, 32'h0);
      idle(20);
      scan(4'h1, '0, '0, '0, '0, 1'b0, 1'b0);
      wr(`FDF_A_STATUS, 32'hff);
      wr(`FDF_A_SETUP, 32'h20 | c);
      ov_s <= 4'h8;
      wr(`FDF_A_CTRL, 32'h1);
      wait_req();
      idle(10);
      rdc(`FDF_A_OV, 32'h0);
      wait_req();
      idle(10);
      rdc(`FDF_A_OV, 32'h8);
      chk("gap", (16 << c) * MS, gap);
    end
    wr(`FDF_A_CTRL, 32'h0);
    finish_test();
  end
endmodule : fault_detect_filter_bench
